/* File: tb_tcrt_timer.sv */
// Testbench: register, pin and mode scenarios for the timer
`timescale 1ns/100ps
`default_nettype none
module tb_tcrt_timer
	import tcrt_pkg::*;
;
	localparam logic [7:0] CTL = TCRT_CONTROL_ADDR;
	localparam logic [7:0] CFG = TCRT_CONFIG_ADDR;
	localparam logic [7:0] RLD = TCRT_RELOAD_LOW_ADDR;
	localparam logic [7:0] CNT = TCRT_COUNT_LOW_ADDR;
	logic		sys_clk, rst, reg_wr, reg_rd, trig, cnt, ext_clk, toggle_out, toggle_out_en_n, irq_request;
	logic [7:0]	reg_addr, reg_wdata, reg_rdata;
	int		fail_count = 0, total_checks = 0, cyc = 0, seed, m;
	// Model: tick divisor for each clock select code; 0 marks the external /8 source
	int		div_q[$] = '{12, 1, 0, 2};
	localparam int TICK_SPAN = 240;
	logic [7:0]	q_lo;
	tcrt_pins u_tcrt_pins (.trigger_direction_pin(trig), .count_toggle_pin(cnt), .ext_clk(ext_clk));
	tcrt_timer u_tcrt_timer (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_clk(ext_clk), .trigger_direction_pin(trig),
		.count_toggle_pin(cnt), .toggle_out(toggle_out), .toggle_out_en_n(toggle_out_en_n), .irq_request(irq_request));
	task automatic chk(input logic [15:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, exp);
		chk({15'h0, got}, {15'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d[7:0];
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask
	// Byte-wise access; the pair has no latching
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		wr(a, d);
		wr(a + 8'h01, {8'h00, d[15:8]});
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		@(negedge sys_clk);
		q = reg_rdata;
	endtask
	task automatic rd16(input logic [7:0] a, input logic [15:0] exp);
		logic [7:0] lo, hi;
		rd(a, lo);
		if (a != CTL && a != CFG) rd(a + 8'h01, hi);
		else hi = exp[15:8];
		chk({hi, lo}, exp);
	endtask
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			test_done();
		end
	end
	initial begin
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 16'h0000};
		seed = 32'h016f;
		repeat (5) @(negedge sys_clk);
		rst = 1'b0;
		rd16(CTL, TCRT_CONTROL_RESET);
		rd16(CFG, TCRT_CONFIG_RESET);
		wr(CTL, 16'h0030);
		rd16(CTL, 16'h0000);
		repeat (3) begin
			m = $random(seed);
			wr16(RLD, m[15:0]);
			rd16(RLD, m[15:0]);
		end
		$display("register test done");
		wr16(RLD, 16'hFFF0);
		wr16(CNT, 16'hFFF0);
		wr(CFG, 16'h000A);
		chk_pin(toggle_out_en_n, 1'b0);
		wr(CTL, 16'h0004);
		for (m = 0; m < 40 && irq_request !== 1'b1; m++) @(negedge sys_clk);
		chk_pin(irq_request, 1'b1);
		chk_pin(toggle_out, 1'b1);
		rd16(CTL, 16'h00C4);
		rd16(CFG, 16'h000E);
		// Sixteen ticks per wrap, so the second wrap lands ten cycles later
		repeat (10) @(negedge sys_clk);
		chk_pin(toggle_out, 1'b0);
		rd16(CTL, 16'h0084);
		wr(CTL, 16'h0000);
		@(negedge sys_clk);
		chk_pin(irq_request, 1'b0);
		wr(CFG, 16'h000C);
		@(negedge sys_clk);
		chk_pin(toggle_out, 1'b1);
		$display("reload up test done");
		wr16(CNT, 16'h1234);
		wr(CTL, 16'h000F);
		u_tcrt_pins.fall_trigger();
		rd16(RLD, 16'h1234);
		rd16(CTL, 16'h004F);
		chk_pin(irq_request, 1'b1);
		wr(CTL, 16'h0007);
		u_tcrt_pins.count_edges(3);
		rd16(CNT, 16'h1237);
		u_tcrt_pins.fall_trigger();
		rd16(RLD, 16'h1234);
		$display("capture test done");
		wr(CFG, 16'h0001);
		u_tcrt_pins.set_dir(1'b0);
		wr16(CNT, 16'h0001);
		wr(CTL, 16'h000F);
		u_tcrt_pins.count_edges(2);
		rd16(CNT, 16'hFFFF);
		u_tcrt_pins.set_dir(1'b1);
		u_tcrt_pins.count_edges(1);
		rd16(CNT, 16'h0000);
		u_tcrt_pins.set_dir(1'b0);
		rd16(RLD, 16'h1234);
		rd16(CTL, 16'h008F);
		$display("count down test done");
		wr(CTL, 16'h0006);
		wr16(RLD, 16'h0010);
		wr16(CNT, 16'h0012);
		u_tcrt_pins.count_edges(3);
		rd16(CNT, 16'hFFFF);
		rd16(CTL, 16'h00C6);
		wr(CTL, 16'h0046);
		chk_pin(irq_request, 1'b0);
		wr(CFG, 16'h0000);
		u_tcrt_pins.set_dir(1'b1);
		wr(CTL, 16'h000E);
		u_tcrt_pins.fall_trigger();
		rd16(CNT, 16'h0010);
		$display("reload down and pin reload test done");
		foreach (div_q[i]) begin
			wr(CTL, 16'h0000);
			wr16(CNT, 16'h0000);
			wr(CFG, 16'(i << TCRT_CLK_SEL_LO_BIT));
			wr(CTL, 16'h0004);
			// The start edge still sees run low and the stop edge still counts: TICK_SPAN edges
			repeat (TICK_SPAN - 2) @(negedge sys_clk);
			wr(CTL, 16'h0000);
			if (div_q[i] == 0) begin
				// Oscillator is asynchronous: 2400 ns hold 52 or 53 of its rising edges
				rd(CNT, q_lo);
				chk_pin(q_lo >= 8'h06 && q_lo <= 8'h07, 1'b1);
			end else begin
				rd16(CNT, 16'(TICK_SPAN / div_q[i]));
			end
		end
		$display("clock source test done");
		test_done();
	end
endmodule
`default_nettype wire

/* File: tcrt_pins.sv */
// Pin partner: trigger/direction and count inputs, free external clock
`timescale 1ns/100ps
`default_nettype none
module tcrt_pins (
	output	var logic	trigger_direction_pin,
	output	var logic	count_toggle_pin,
	output	var logic	ext_clk
);
	initial begin
		trigger_direction_pin = 1'b1;
		count_toggle_pin = 1'b1;
		ext_clk = 1'b0;
	end
	// Oscillator runs free, unrelated to the system clock
	always #23 ext_clk = ~ext_clk;
	// Low for four cycles so the synchroniser cannot miss it
	task automatic fall_trigger();
		trigger_direction_pin = 1'b0;
		#40;
		trigger_direction_pin = 1'b1;
		#60;
	endtask
	task automatic set_dir(input logic up);
		trigger_direction_pin = up;
		#60;
	endtask
	task automatic count_edges(input int n);
		repeat (n) begin
			count_toggle_pin = 1'b0;
			#40;
			count_toggle_pin = 1'b1;
			#40;
		end
	endtask
endmodule
`default_nettype wire

/* File: tcrt_pkg.sv */
// Package: register map, field positions and reset values of the capture/reload/toggle timer
package tcrt_pkg;
	localparam logic [7:0]  TCRT_CONTROL_ADDR       = 8'hC8;
	localparam logic [7:0]  TCRT_CONFIG_ADDR        = 8'hC9;
	localparam logic [7:0]  TCRT_COUNT_LOW_ADDR     = 8'hCC;
	localparam logic [7:0]  TCRT_COUNT_HIGH_ADDR    = 8'hCD;
	localparam logic [7:0]  TCRT_RELOAD_LOW_ADDR    = 8'hCA;
	localparam logic [7:0]  TCRT_RELOAD_HIGH_ADDR   = 8'hCB;
	localparam int          TCRT_WRAP_FLAG_BIT      = 7;
	localparam int          TCRT_EXT_FLAG_BIT       = 6;
	localparam int          TCRT_EXT_ENABLE_BIT     = 3;
	localparam int          TCRT_RUN_BIT            = 2;
	localparam int          TCRT_SOURCE_BIT         = 1;
	localparam int          TCRT_CAPTURE_BIT        = 0;
	localparam int          TCRT_CLK_SEL_HI_BIT     = 4;
	localparam int          TCRT_CLK_SEL_LO_BIT     = 3;
	localparam int          TCRT_TOGGLE_STATE_BIT   = 2;
	localparam int          TCRT_TOGGLE_OE_BIT      = 1;
	localparam int          TCRT_COUNT_DOWN_BIT     = 0;
	localparam logic [7:0]  TCRT_CONTROL_RESET      = 8'h00;
	localparam logic [7:0]  TCRT_CONFIG_RESET       = 8'h00;
	localparam logic [7:0]  TCRT_CONTROL_MASK       = 8'hCF;
	localparam logic [7:0]  TCRT_CONFIG_MASK        = 8'h1F;
	localparam logic [15:0] TCRT_COUNT_MAX          = 16'hFFFF;
	localparam logic [15:0] TCRT_COUNT_ZERO         = 16'h0000;
	localparam logic [3:0]  TCRT_DIV12_LAST         = 4'hB;
	localparam logic [2:0]  TCRT_DIV8_LAST          = 3'h7;
	localparam logic [1:0]  TCRT_CLK_DIV12          = 2'h0;
	localparam logic [1:0]  TCRT_CLK_SYS            = 2'h1;
	localparam logic [1:0]  TCRT_CLK_EXT8           = 2'h2;
	localparam logic [1:0]  TCRT_CLK_DIV2           = 2'h3;
endpackage

/* File: tcrt_timer.sv */
// Module: 16-bit up/down timer with capture, auto-reload and toggle output
// Function
// [RULE_01] Capture mode with pin enable copies count into reload pair on trigger fall.
// [RULE_02] A capture sets the external event flag, bit 6 of control.
// [RULE_03] Count overflow sets the wrap flag, bit 7 of control.
// [RULE_04] Capture mode counting down wraps 0000 to FFFF as underflow, sets wrap flag.
// [RULE_05] Capture mode needs select and run set; captures also need pin enable.
// [RULE_06] With pin enable clear, trigger pin transitions are ignored.
// [RULE_07] Auto-reload up: on overflow set wrap flag and load reload pair.
// [RULE_08] Auto-reload with pin enable and no count-down reloads on trigger fall.
// [RULE_09] With count-down enabled the pin only sets direction, no reload or event.
// [RULE_10] Auto-reload down: count equal to reload pair underflows, loads FFFF.
// [RULE_11] Select clear means auto-reload; run bit set starts counting.
// [RULE_12] Auto-reload inverts external event flag on every wrap, no interrupt.
// [RULE_13] Toggle output inverts on each overflow or underflow. The code inverts it only while the output enable bit of config is set.
// [RULE_14] Software clears select bits, sets output enable, then sets run.
// [RULE_15] Toggle state bit reads output level; writing it forces the output.
// [RULE_16] Software picks clock and reload so wraps run at twice toggle rate.
// [RULE_17] With count-down enabled, direction pin high counts up, low down.
// [RULE_18] Source select set counts falling edges of the count pin.
// [RULE_19] Both flags stay set until software clears them; the external flag still inverts on each auto-reload wrap.
// [RULE_20] Reset clears all control bits; reserved bits 5 and 4 read zero.
`timescale 1ns/100ps
`default_nettype none
module tcrt_timer
	import tcrt_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       ext_clk,
	input  wire logic       trigger_direction_pin,
	input  wire logic       count_toggle_pin,
	output logic            toggle_out,
	output logic            toggle_out_en_n,
	output logic            irq_request
);
	logic [7:0]  timer_control;
	logic [7:0]  timer_configuration;
	logic [15:0] count;
	logic [15:0] reload;
	logic [2:0]  trig_sync;
	logic [2:0]  cnt_sync;
	logic [2:0]  ext_sync;
	logic [3:0]  div12;
	logic        div2;
	logic [2:0]  div8;
	logic        tick;
	logic        trig_fall;
	logic        wrap;
	logic        count_up;
	logic        capture;
	logic        reload_pin;
	logic        ctl_wr;
	logic        cfg_wr;
	logic        wrap_flag;
	logic        external_event_flag;
	logic        external_pin_enable;
	logic        run_bit;
	logic        count_source_select;
	logic        capture_reload_select;
	logic        count_down_enable;
	logic [15:0] next_count;

	assign wrap_flag             = timer_control[TCRT_WRAP_FLAG_BIT];
	assign external_event_flag   = timer_control[TCRT_EXT_FLAG_BIT];
	assign external_pin_enable   = timer_control[TCRT_EXT_ENABLE_BIT];
	assign run_bit               = timer_control[TCRT_RUN_BIT];
	assign count_source_select   = timer_control[TCRT_SOURCE_BIT];
	assign capture_reload_select = timer_control[TCRT_CAPTURE_BIT];
	assign count_down_enable     = timer_configuration[TCRT_COUNT_DOWN_BIT];
	assign ctl_wr = reg_wr && (reg_addr == TCRT_CONTROL_ADDR);
	assign cfg_wr = reg_wr && (reg_addr == TCRT_CONFIG_ADDR);

	// Pins pass two flops; the third stage feeds only the edge detectors
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			trig_sync <= 3'h0;
			cnt_sync  <= 3'h0;
			ext_sync  <= 3'h0;
		end else begin
			trig_sync <= {trig_sync[1:0], trigger_direction_pin};
			cnt_sync  <= {cnt_sync[1:0], count_toggle_pin};
			ext_sync  <= {ext_sync[1:0], ext_clk};
		end
	end

	// Prescalers free-run so the tick phase does not depend on run
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div12 <= 4'h0;
			div2  <= 1'b0;
			div8  <= 3'h0;
		end else begin
			div12 <= (div12 == TCRT_DIV12_LAST) ? 4'h0 : div12 + 4'h1;
			div2  <= ~div2;
			if (ext_sync[1] && !ext_sync[2])
				div8 <= div8 + 3'h1;
		end
	end

	always_comb begin
		tick = 1'b0;
		if (count_source_select) begin
			tick = cnt_sync[2] && !cnt_sync[1]; // [RULE_18]
		end else begin
			unique case (timer_configuration[TCRT_CLK_SEL_HI_BIT:TCRT_CLK_SEL_LO_BIT])
				TCRT_CLK_DIV12: tick = (div12 == TCRT_DIV12_LAST);
				TCRT_CLK_SYS:   tick = 1'b1;
				TCRT_CLK_EXT8:  tick = ext_sync[1] && !ext_sync[2] && (div8 == TCRT_DIV8_LAST);
				TCRT_CLK_DIV2:  tick = div2;
			endcase
		end
	end

	// Edges of the trigger pin only count with pin enable set and count-down off
	assign trig_fall  = trig_sync[2] && !trig_sync[1] && external_pin_enable && !count_down_enable; // [RULE_06] [RULE_09]
	assign count_up   = !count_down_enable || trig_sync[1]; // [RULE_17]
	assign capture    = capture_reload_select && trig_fall; // [RULE_01] [RULE_05]
	assign reload_pin = !capture_reload_select && trig_fall; // [RULE_08]

	always_comb begin
		wrap       = 1'b0;
		next_count = count;
		if (run_bit && tick) begin // [RULE_11]
			if (count_up) begin
				wrap       = (count == TCRT_COUNT_MAX); // [RULE_03]
				next_count = count + 16'h0001;
				if (wrap && !capture_reload_select)
					next_count = reload; // [RULE_07]
			end else if (capture_reload_select) begin
				wrap       = (count == TCRT_COUNT_ZERO); // [RULE_04]
				next_count = count - 16'h0001;
			end else begin
				wrap       = (count == reload); // [RULE_10]
				next_count = wrap ? TCRT_COUNT_MAX : count - 16'h0001;
			end
		end
		if (reload_pin)
			next_count = reload; // [RULE_08]
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count <= 16'h0000;
		end else if (reg_wr && reg_addr == TCRT_COUNT_LOW_ADDR) begin
			count <= {count[15:8], reg_wdata};
		end else if (reg_wr && reg_addr == TCRT_COUNT_HIGH_ADDR) begin
			count <= {reg_wdata, count[7:0]};
		end else begin
			count <= next_count;
		end
	end

	// Capture wins over a software write in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reload <= 16'h0000;
		end else if (capture) begin
			reload <= count; // [RULE_01]
		end else if (reg_wr && reg_addr == TCRT_RELOAD_LOW_ADDR) begin
			reload <= {reload[15:8], reg_wdata};
		end else if (reg_wr && reg_addr == TCRT_RELOAD_HIGH_ADDR) begin
			reload <= {reg_wdata, reload[7:0]};
		end
	end

	// Hardware set beats a software clear in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			timer_control <= TCRT_CONTROL_RESET; // [RULE_20]
		end else begin
			if (ctl_wr)
				timer_control <= reg_wdata & TCRT_CONTROL_MASK; // [RULE_20]
			if (wrap)
				timer_control[TCRT_WRAP_FLAG_BIT] <= 1'b1; // [RULE_03] [RULE_19]
			if (capture)
				timer_control[TCRT_EXT_FLAG_BIT] <= 1'b1; // [RULE_02] [RULE_19]
			else if (wrap && !capture_reload_select)
				timer_control[TCRT_EXT_FLAG_BIT] <= ctl_wr ? ~reg_wdata[TCRT_EXT_FLAG_BIT]
					: ~external_event_flag; // [RULE_12]
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			timer_configuration <= TCRT_CONFIG_RESET;
		end else begin
			if (cfg_wr)
				timer_configuration <= reg_wdata & TCRT_CONFIG_MASK;
			else if (wrap && timer_configuration[TCRT_TOGGLE_OE_BIT])
				timer_configuration[TCRT_TOGGLE_STATE_BIT] <= ~timer_configuration[TCRT_TOGGLE_STATE_BIT]; // [RULE_13]
		end
	end

	assign toggle_out      = timer_configuration[TCRT_TOGGLE_STATE_BIT]; // [RULE_15]
	assign toggle_out_en_n = !timer_configuration[TCRT_TOGGLE_OE_BIT];
	// Only the capture event raises the external flag as an interrupt source
	assign irq_request     = wrap_flag || (external_event_flag && capture_reload_select); // [RULE_02] [RULE_12]

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				TCRT_CONTROL_ADDR:     reg_rdata <= timer_control & TCRT_CONTROL_MASK; // [RULE_20]
				TCRT_CONFIG_ADDR:      reg_rdata <= timer_configuration; // [RULE_15]
				TCRT_COUNT_LOW_ADDR:   reg_rdata <= count[7:0];
				TCRT_COUNT_HIGH_ADDR:  reg_rdata <= count[15:8];
				TCRT_RELOAD_LOW_ADDR:  reg_rdata <= reload[7:0];
				TCRT_RELOAD_HIGH_ADDR: reg_rdata <= reload[15:8];
				default:               reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: tcrt_timer_props.sv */
// Checker: port-level properties of the timer
`timescale 1ns/100ps
`default_nettype none
module tcrt_timer_props
	import tcrt_pkg::*;
(
	input	wire logic		sys_clk,
	input	wire logic		rst,
	input	wire logic [7:0]	reg_addr,
	input	wire logic		reg_wr,
	input	wire logic		reg_rd,
	input	wire logic [7:0]	reg_wdata,
	input	wire logic [7:0]	reg_rdata,
	input	wire logic		toggle_out,
	input	wire logic		toggle_out_en_n,
	input	wire logic		irq_request
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_cfg_wr;
		reg_wr && reg_addr == TCRT_CONFIG_ADDR;
	endsequence
	sequence s_ctl_rd;
		reg_rd && reg_addr == TCRT_CONTROL_ADDR;
	endsequence
	a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_force_toggle: assert property (s_cfg_wr |=> toggle_out == $past(reg_wdata[2]))
		else $error("toggle level not forced by write");
	a_oe_follows: assert property (s_cfg_wr |=> toggle_out_en_n == !$past(reg_wdata[1]))
		else $error("output enable not following write");
	a_toggle_cause: assert property ($changed(toggle_out) |-> !$past(toggle_out_en_n) || $past(reg_wr && reg_addr == TCRT_CONFIG_ADDR))
		else $error("toggle moved while output disabled");
	a_irq_clear: assert property ($fell(irq_request) |-> $past(reg_wr && reg_addr == TCRT_CONTROL_ADDR))
		else $error("flag cleared without software write");
	a_reset_clear: assert property ($fell(rst) |-> !irq_request && toggle_out_en_n && !toggle_out)
		else $error("outputs not idle after reset");
	a_ctl_reserved: assert property (s_ctl_rd |=> reg_rdata[5:4] == 2'h0)
		else $error("reserved control bits read nonzero");
	a_cfg_reserved: assert property (reg_rd && reg_addr == TCRT_CONFIG_ADDR |=> reg_rdata[7:5] == 3'h0)
		else $error("reserved config bits read nonzero");
endmodule
bind tcrt_timer tcrt_timer_props u_tcrt_timer_props (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .toggle_out(toggle_out),
	.toggle_out_en_n(toggle_out_en_n), .irq_request(irq_request));
`default_nettype wire
